// [hw/fx_consts.vh]
// Constants shared by the function output effect block and its mapping memory.
// Assumes a single 40 MHz clock and a one millisecond effect tick derived from it.
`ifndef FX_CONSTS_VH
`define FX_CONSTS_VH

`define FX_CLK_MHZ 40
`define FX_TICK_US 1000
`define FX_NOUT 8
`define FX_NFN 29
`define FX_FN_LAST 5'd28
`define FX_MM_NFN 9
`define FX_ACT_W 12
`define FX_ACT_BUF 8
`define FX_ACT_STOP 9
`define FX_ACT_SHUNT 10
`define FX_ACT_ABD 11
`define FX_FULL 8'hff
`define FX_ZERO 8'h00
`define FX_FIRE_FLOOR 8'h40
`define FX_KICK_UNIT 15'd100
`define FX_FLASH_UNIT 12'd10
`define FX_BUF_MIN 11'd100
`define FX_LFSR_SEED 16'hace1
`define FX_MAP_AW 6
`define FX_MAP_DEPTH 64

`endif

// [hw/fx_map_mem.v]
// Function mapping memory: one write port, one registered read port.
// Assumes the owner scans it continuously; reset clears every entry.
`timescale 1ns/10ps
`include "fx_consts.vh"

module fx_map_mem #(
  parameter AW = `FX_MAP_AW,
  parameter DW = `FX_ACT_W,
  parameter DEPTH = `FX_MAP_DEPTH
) (
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);

  reg [DW-1:0] mem_q [0:DEPTH-1];
  reg [DW-1:0] rd_q;
  integer k;

  // Reset empties the map, so no function drives any action as delivered.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_q[k] <= {DW{1'b0}};
      end
      rd_q <= {DW{1'b0}};
    end else if (clk_en) begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_q <= mem_q[rd_addr];
    end
  end

  assign rd_data = rd_q;

endmodule // fx_map_mem

// [hw/fx_effects.v]
// Effect generator for eight function outputs and the buffer output of a vehicle decoder.
// Assumes all inputs are synchronous to ref_clk; out_level is a duty level for a PWM stage.
`timescale 1ns/10ps
`include "fx_consts.vh"

module fx_effects #(
  parameter TICK_CYCLES = `FX_CLK_MHZ * `FX_TICK_US,
  parameter TICK_W = 16
) (
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  input wire [`FX_NFN-1:0] fn_state,
  input wire dir_fwd,
  input wire mm_mode,
  input wire switch_input,
  input wire [`FX_ACT_W-1:0] switch_actions,
  input wire [7:0] motor_level,
  input wire [7:0] speed_step,
  input wire [7:0] dim_en,
  input wire [7:0] flash_en,
  input wire [7:0] kick_en,
  input wire [7:0] fire_en,
  input wire [7:0] thresh_en,
  input wire [7:0] invert,
  input wire [7:0] dim_time,
  input wire [7:0] kick_time,
  input wire [31:0] flash_period,
  input wire [7:0] volt_threshold,
  input wire map_wr_en,
  input wire map_wr_rev,
  input wire [4:0] map_wr_fn,
  input wire [`FX_ACT_W-1:0] map_wr_actions,
  output wire [63:0] out_level,
  output wire buffer_charge_control,
  output wire stop_request,
  output wire shunting_gear,
  output wire accel_brake_delay_enable,
  output wire [`FX_NFN-1:0] susi_functions,
  output wire [7:0] susi_speed
);

  localparam [TICK_W-1:0] TICK_LAST = TICK_CYCLES[TICK_W-1:0] - 1'b1;
  localparam [4:0] FN_LAST = `FX_FN_LAST;
  localparam [1:0] BUF_SEED = 2'd0;
  localparam [1:0] BUF_WAIT = 2'd1;
  localparam [1:0] BUF_ON = 2'd2;

  // One step of a ramp toward its target.
  function [7:0] step_toward;
    input [7:0] cur;
    input [7:0] tgt;
    begin
      if (cur < tgt) begin
        step_toward = cur + 8'h01;
      end else if (cur > tgt) begin
        step_toward = cur - 8'h01;
      end else begin
        step_toward = cur;
      end
    end
  endfunction

  reg [TICK_W-1:0] tick_cnt_q;
  reg tick_q;
  reg [15:0] lfsr_q;
  reg [4:0] scan_fn_q;
  reg [4:0] scan_fn_d1_q;
  reg scan_vld_q;
  reg [`FX_ACT_W-1:0] acc_q;
  reg acc_buf_q;
  reg [`FX_ACT_W-1:0] act_q;
  reg buf_mapped_q;
  reg [7:0] dim_cnt_q;
  reg [3:0] phase_q;
  reg [11:0] flash_cnt_q [0:3];
  reg [14:0] kick_cnt_q [0:7];
  reg [7:0] fire_lvl_q [0:7];
  reg [7:0] prev_cmd_q;
  reg [63:0] level_q;
  reg [1:0] buf_state_q;
  reg [10:0] buf_cnt_q;
  reg buf_out_q;
  reg stop_q;
  reg shunt_q;
  reg abd_q;
  reg [`FX_NFN-1:0] susi_fn_q;
  reg [7:0] susi_speed_q;

  wire [`FX_ACT_W-1:0] map_rd;
  wire [`FX_NFN-1:0] fn_eff;
  wire [`FX_ACT_W-1:0] act_now;
  wire over;
  wire ramp_step;
  reg [7:0] on_d;
  reg [63:0] target_d;
  integer i, fi, ki, li;

  // The alternate protocol only reaches F0 to F8, higher functions are masked off.
  assign fn_eff = mm_mode ? (fn_state & {{(`FX_NFN-`FX_MM_NFN){1'b0}}, {`FX_MM_NFN{1'b1}}})
                          : fn_state;
  // Switching input adds its own action set to the mapped ones.
  assign act_now = act_q | (switch_input ? switch_actions : {`FX_ACT_W{1'b0}});
  assign over = motor_level > volt_threshold;
  assign ramp_step = tick_q && (dim_cnt_q == dim_time);

  fx_map_mem u_map (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .wr_en(map_wr_en),
    .wr_addr({map_wr_rev, map_wr_fn}),
    .wr_data(map_wr_actions),
    .rd_addr({~dir_fwd, scan_fn_q}),
    .rd_data(map_rd)
  );

  // Common tick and a free-running LFSR; inputs are folded in so units differ.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q <= 1'b0;
      lfsr_q <= `FX_LFSR_SEED;
    end else if (clk_en) begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? {TICK_W{1'b0}} : tick_cnt_q + 1'b1;
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]
                 ^ switch_input ^ motor_level[0] ^ speed_step[0]};
    end
  end

  // Continuous scan of the map for the current direction; a full pass takes 29 cycles.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      scan_fn_q <= 5'd0;
      scan_fn_d1_q <= 5'd0;
      scan_vld_q <= 1'b0;
      acc_q <= {`FX_ACT_W{1'b0}};
      acc_buf_q <= 1'b0;
      act_q <= {`FX_ACT_W{1'b0}};
      buf_mapped_q <= 1'b0;
    end else if (clk_en) begin
      scan_fn_q <= (scan_fn_q == FN_LAST) ? 5'd0 : scan_fn_q + 5'd1;
      scan_fn_d1_q <= scan_fn_q;
      scan_vld_q <= 1'b1;
      if (scan_vld_q) begin
        if (scan_fn_d1_q == FN_LAST) begin
          act_q <= acc_q | (fn_eff[scan_fn_d1_q] ? map_rd : {`FX_ACT_W{1'b0}});
          buf_mapped_q <= acc_buf_q | map_rd[`FX_ACT_BUF];
          acc_q <= {`FX_ACT_W{1'b0}};
          acc_buf_q <= 1'b0;
        end else begin
          acc_q <= acc_q | (fn_eff[scan_fn_d1_q] ? map_rd : {`FX_ACT_W{1'b0}});
          acc_buf_q <= acc_buf_q | map_rd[`FX_ACT_BUF];
        end
      end
    end
  end

  // Shared dimming divider and per-pair flash timers.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      dim_cnt_q <= 8'h00;
      phase_q <= 4'h0;
      for (fi = 0; fi < 4; fi = fi + 1) begin
        flash_cnt_q[fi] <= 12'h000;
      end
    end else if (clk_en && tick_q) begin
      dim_cnt_q <= (dim_cnt_q >= dim_time) ? 8'h00 : dim_cnt_q + 8'h01;
      for (fi = 0; fi < 4; fi = fi + 1) begin
        if (flash_cnt_q[fi] + 12'h001 >= {4'h0, flash_period[fi*8 +: 8]} * `FX_FLASH_UNIT) begin
          flash_cnt_q[fi] <= 12'h000;
          phase_q[fi] <= ~phase_q[fi];
        end else begin
          flash_cnt_q[fi] <= flash_cnt_q[fi] + 12'h001;
        end
      end
    end
  end

  // Kick timers load on a rising command and fire levels resample at random ticks.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      prev_cmd_q <= 8'h00;
      for (ki = 0; ki < `FX_NOUT; ki = ki + 1) begin
        kick_cnt_q[ki] <= 15'd0;
        fire_lvl_q[ki] <= `FX_FULL;
      end
    end else if (clk_en) begin
      prev_cmd_q <= act_now[7:0];
      for (ki = 0; ki < `FX_NOUT; ki = ki + 1) begin
        if (kick_en[ki] && act_now[ki] && !prev_cmd_q[ki]) begin
          kick_cnt_q[ki] <= {7'd0, kick_time} * `FX_KICK_UNIT;
        end else if (!act_now[ki]) begin
          kick_cnt_q[ki] <= 15'd0;
        end else if (tick_q && kick_cnt_q[ki] != 15'd0) begin
          kick_cnt_q[ki] <= kick_cnt_q[ki] - 15'd1;
        end
        if (tick_q && lfsr_q[ki] && lfsr_q[ki+8]) begin
          fire_lvl_q[ki] <= lfsr_q[15:8] | `FX_FIRE_FLOOR;
        end
      end
    end
  end

  // Switching decision and target level of each output.
  always @* begin
    on_d = 8'h00;
    target_d = 64'h0;
    for (i = 0; i < `FX_NOUT; i = i + 1) begin
      if (kick_en[i]) begin
        on_d[i] = (kick_cnt_q[i] != 15'd0);
      end else if (thresh_en[i]) begin
        on_d[i] = act_now[i] & (over ~^ invert[i]);
      end else if (flash_en[i]) begin
        on_d[i] = act_now[i] & (phase_q[i/2] ^ invert[i]);
      end else begin
        on_d[i] = act_now[i] ^ invert[i];
      end
      if (!on_d[i]) begin
        target_d[i*8 +: 8] = `FX_ZERO;
      end else if (fire_en[i]) begin
        target_d[i*8 +: 8] = fire_lvl_q[i];
      end else begin
        target_d[i*8 +: 8] = `FX_FULL;
      end
    end
  end

  // Dimmed outputs without kick move one step per ramp pulse; the rest follow at once.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      level_q <= 64'h0;
    end else if (clk_en) begin
      for (li = 0; li < `FX_NOUT; li = li + 1) begin
        if (dim_en[li] && !kick_en[li]) begin
          if (ramp_step) begin
            level_q[li*8 +: 8] <= step_toward(level_q[li*8 +: 8], target_d[li*8 +: 8]);
          end
        end else begin
          level_q[li*8 +: 8] <= target_d[li*8 +: 8];
        end
      end
    end
  end

  // Buffer output waits a random number of ticks after reset before charging.
  // The LFSR is only as random as the inputs seen before the first tick.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      buf_state_q <= BUF_SEED;
      buf_cnt_q <= 11'd0;
      buf_out_q <= 1'b0;
    end else if (clk_en) begin
      case (buf_state_q)
        BUF_SEED: begin
          if (tick_q) begin
            buf_cnt_q <= {1'b0, lfsr_q[9:0]} + `FX_BUF_MIN;
            buf_state_q <= BUF_WAIT;
          end
        end
        BUF_WAIT: begin
          if (tick_q) begin
            if (buf_cnt_q == 11'd0) begin
              buf_state_q <= BUF_ON;
            end else begin
              buf_cnt_q <= buf_cnt_q - 11'd1;
            end
          end
        end
        BUF_ON: begin
          buf_state_q <= BUF_ON;
        end
        default: begin
          buf_state_q <= BUF_SEED;
        end
      endcase
      buf_out_q <= (buf_state_q == BUF_ON) &&
                   (!buf_mapped_q || act_now[`FX_ACT_BUF]);
    end
  end

  // Special functions and the status mirrored to the sound module side.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      stop_q <= 1'b0;
      shunt_q <= 1'b0;
      abd_q <= 1'b0;
      susi_fn_q <= {`FX_NFN{1'b0}};
      susi_speed_q <= 8'h00;
    end else if (clk_en) begin
      stop_q <= act_now[`FX_ACT_STOP];
      shunt_q <= act_now[`FX_ACT_SHUNT];
      abd_q <= act_now[`FX_ACT_ABD];
      susi_fn_q <= fn_eff;
      susi_speed_q <= speed_step;
    end
  end

  assign out_level = level_q;
  assign buffer_charge_control = buf_out_q;
  assign stop_request = stop_q;
  assign shunting_gear = shunt_q;
  assign accel_brake_delay_enable = abd_q;
  assign susi_functions = susi_fn_q;
  assign susi_speed = susi_speed_q;

endmodule // fx_effects

// [tb/fx_effects_props.sv]
// Checker for fx_effects, bound to the ports of its top module.
// Assumes one clock, ref_clk, and the synchronous active low rstn.
`timescale 1ns/10ps
`include "fx_consts.vh"
module fx_effects_props #(
  parameter TICK_CYCLES = 4
) (
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  input wire [`FX_NFN-1:0] fn_state,
  input wire mm_mode,
  input wire switch_input,
  input wire [`FX_ACT_W-1:0] switch_actions,
  input wire [7:0] speed_step,
  input wire [63:0] out_level,
  input wire buffer_charge_control,
  input wire stop_request,
  input wire shunting_gear,
  input wire accel_brake_delay_enable,
  input wire [`FX_NFN-1:0] susi_functions,
  input wire [7:0] susi_speed
);
  localparam int BUF_LO = 100 * TICK_CYCLES;
  localparam int BUF_MAX = 1127 * TICK_CYCLES;
  int cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Cycles since reset; it saturates so the late bound is checked only once.
  always @(posedge ref_clk) begin
    if (!rstn) cnt_q <= 0;
    else if (clk_en && cnt_q < BUF_MAX) cnt_q <= cnt_q + 1;
  end
  sequence s_sw(int b);
    clk_en && switch_input && switch_actions[b];
  endsequence
  a_reset_clear: assert property (disable iff (1'b0)
    !rstn && clk_en |=> out_level == 64'h0 && !buffer_charge_control) else $error("not cleared");
  a_freeze_hold: assert property (!clk_en |=> $stable(out_level) && $stable(susi_speed))
    else $error("state moved while frozen");
  a_susi_speed: assert property (clk_en |=> susi_speed == $past(speed_step))
    else $error("speed not mirrored");
  a_susi_funcs: assert property (clk_en |=> susi_functions ==
    ($past(fn_state) & ($past(mm_mode) ? 29'h1ff : 29'h1fffffff))) else $error("bad functions");
  a_switch_stop: assert property (s_sw(9) |-> ##[1:2] stop_request)
    else $error("stop not switched");
  a_switch_shunt: assert property (s_sw(10) |-> ##[1:2] shunting_gear)
    else $error("shunting not switched");
  a_switch_delay: assert property (s_sw(11) |-> ##[1:2] accel_brake_delay_enable)
    else $error("delay enable not switched");
  a_buf_early: assert property (buffer_charge_control |-> cnt_q >= BUF_LO)
    else $error("buffer on too soon");
  a_buf_late: assert property (cnt_q == BUF_MAX - 1 && clk_en |=> buffer_charge_control)
    else $error("buffer never on");
endmodule // fx_effects_props

// [tb/fx_lamp_model.sv]
// Lamp load on one output: counts level changes and keeps the dimmest lit level.
// Assumes level is a registered duty level; clr restarts both figures.
`timescale 1ns/10ps
module fx_lamp_model (
  input wire ref_clk,
  input wire clr,
  input wire [7:0] level,
  output logic [15:0] chg_q,
  output logic [7:0] min_q
);
  logic [7:0] last_q;
  // A lamp only sees its voltage, so these two figures are all it can report.
  always @(posedge ref_clk) begin
    last_q <= level;
    if (clr) begin
      chg_q <= 16'h0;
      min_q <= 8'hff;
    end else begin
      if (level != last_q) chg_q <= chg_q + 16'h1;
      if (level != 8'h0 && level < min_q) min_q <= level;
    end
  end
endmodule // fx_lamp_model

// [tb/tb.sv]
// Self-checking bench for fx_effects with one lamp model on a chosen output.
// Assumes the design files and the checker are compiled before this file.
`timescale 1ns/10ps
`include "fx_consts.vh"
module tb;
  localparam int TICK = 4;
  logic ref_clk = 0, rstn = 0, clk_en = 1, dir_fwd = 1, mm_mode = 0, clr = 1;
  logic switch_input = 0, map_wr_en = 0, map_wr_rev = 0;
  logic [28:0] fn_state = 29'h0;
  logic [11:0] switch_actions = 12'h0, map_wr_actions = 12'h0;
  logic [7:0] motor_level = 8'h0, speed_step = 8'h0, dim_en = 8'h0, flash_en = 8'h0;
  logic [7:0] kick_en = 8'h08, fire_en = 8'h0, thresh_en = 8'h0, invert = 8'h0;
  logic [7:0] dim_time = 8'h0, kick_time = 8'h1, volt_threshold = 8'h40, min_lit;
  logic [31:0] flash_period = 32'h01000000, rnd = 32'h0128f3dc;
  logic [4:0] map_wr_fn = 5'h0;
  logic [63:0] out_level;
  logic buffer_charge_control, stop_request, shunting_gear, accel_brake_delay_enable;
  logic [28:0] susi_functions;
  logic [7:0] susi_speed;
  logic [15:0] n_chg;
  logic [28:0] exp_fn[$];
  int n_errors = 0, n_compared = 0, c = 0, lamp_sel = 6;
  // Free running clock; everything else moves on its rising edge.
  always #12.5 ref_clk = ~ref_clk;
  fx_effects #(.TICK_CYCLES(TICK)) fx_effects_i (.ref_clk, .rstn, .clk_en, .fn_state,
    .dir_fwd, .mm_mode, .switch_input, .switch_actions, .motor_level, .speed_step, .dim_en,
    .flash_en, .kick_en, .fire_en, .thresh_en, .invert, .dim_time, .kick_time, .flash_period,
    .volt_threshold, .map_wr_en, .map_wr_rev, .map_wr_fn, .map_wr_actions, .out_level,
    .buffer_charge_control, .stop_request, .shunting_gear, .accel_brake_delay_enable,
    .susi_functions, .susi_speed);
  fx_lamp_model fx_lamp_model_i (.ref_clk, .clr, .level(out_level[lamp_sel*8+:8]),
    .chg_q(n_chg), .min_q(min_lit));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Map words go back to back; the caller drops the strobe after the last one.
  task automatic mapw(logic rev, logic [4:0] fn, logic [11:0] act);
    map_wr_en <= 1'b1;
    map_wr_rev <= rev;
    map_wr_fn <= fn;
    map_wr_actions <= act;
    step();
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Buffer wait, mapping both ways, kick, threshold, dimming, effects, switching input.
  initial begin
    step(8);
    rstn <= 1'b1;
    while (buffer_charge_control !== 1'b1 && c < 5000) begin
      step();
      #1 c++;
    end
    if (c == 5000) begin
      n_errors++;
      report_and_stop();
    end
    chk("buffer wait", c >= 100 * TICK, 1);
    step(4600 - c);
    mapw(0, 5'd3, 12'h401);
    mapw(1, 5'd3, 12'h002);
    mapw(0, 5'd5, 12'h008);
    mapw(0, 5'd6, 12'h010);
    mapw(0, 5'd7, 12'h0a0);
    mapw(0, 5'd9, 12'h100);
    map_wr_en <= 1'b0;
    invert <= 8'h04;
    fn_state <= 29'h8;
    step(70);
    #1 chk("lights fwd", out_level[23:0], 24'hff00ff);
    chk("shunt and buffer", {shunting_gear, buffer_charge_control}, 2'b10);
    step();
    dir_fwd <= 1'b0;
    fn_state <= 29'h208;
    step(70);
    #1 chk("lights rev", out_level[23:0], 24'hffff00);
    chk("buffer unmapped", buffer_charge_control, 1);
    $display("test mapping done");
    step();
    dir_fwd <= 1'b1;
    fn_state <= 29'h20;
    step(70);
    #1 chk("kick on", out_level[31:24], 8'hff);
    step(100 * TICK + 50);
    #1 chk("kick off", out_level[31:24], 8'h00);
    $display("test kick done");
    for (int i = 0; i < 4; i++) begin
      step();
      thresh_en <= 8'h10;
      fn_state <= 29'h40;
      motor_level <= i[0] ? 8'h40 : 8'h41;
      invert[4] <= i[1];
      step(70);
      #1 chk("threshold", out_level[39:32], (i[0] ^ i[1]) ? 8'hff : 8'h00);
    end
    $display("test threshold done");
    for (int i = 0; i < 2; i++) begin
      step();
      dim_en <= 8'h20;
      fn_state <= i ? 29'h0 : 29'h80;
      step(300);
      #1 chk("ramp", out_level[47:40] != 8'h00 && out_level[47:40] != 8'hff, 1);
      step(1200);
      #1 chk("ramp end", out_level[47:40], i ? 8'h00 : 8'hff);
    end
    $display("test dimming done");
    for (int i = 0; i < 3; i++) begin
      step();
      lamp_sel <= i ? 7 : 6;
      fn_state <= 29'h80; // Flashing needs its command on, so output seven is commanded.
      fire_en[6] <= 1'b1;
      invert[7:6] <= 2'b11;
      flash_en[7] <= 1'b1;
      dim_en[7] <= i == 2;
      clr <= 1'b1;
      step();
      clr <= 1'b0;
      step(200);
      #1 if (i == 0) chk("fire floor", min_lit >= 8'h40 && n_chg > 0, 1);
      if (i == 1) chk("flash", n_chg >= 4 && n_chg <= 6 && min_lit == 8'hff, 1);
      if (i == 2) chk("fading", n_chg > 20, 1);
    end
    $display("test effects done");
    step();
    switch_input <= 1'b1;
    for (int b = 0; b < 3; b++) begin
      step();
      switch_actions <= 12'h200 << b;
      step(2);
      #1 chk("switched", {accel_brake_delay_enable, shunting_gear, stop_request}, 3'h1 << b);
    end
    for (int i = 0; i < 16; i++) begin
      step();
      rnd = lfsr(rnd);
      fn_state <= rnd[28:0];
      exp_fn.push_back(rnd[31] ? {20'h0, rnd[8:0]} : rnd[28:0]);
      speed_step <= rnd[15:8];
      mm_mode <= rnd[31];
      step();
      #1 chk("susi fn", susi_functions, exp_fn.pop_front());
      chk("susi speed", susi_speed, rnd[15:8]);
    end
    step();
    clk_en <= 1'b0;
    speed_step <= ~rnd[15:8];
    step(5);
    #1 chk("frozen", susi_speed, rnd[15:8]);
    $display("test susi done");
    report_and_stop();
  end
endmodule // tb
bind fx_effects fx_effects_props #(.TICK_CYCLES(TICK_CYCLES)) fx_effects_props_i (
  .ref_clk, .rstn, .clk_en, .fn_state, .mm_mode, .switch_input, .switch_actions,
  .speed_step, .out_level, .buffer_charge_control, .stop_request, .shunting_gear,
  .accel_brake_delay_enable, .susi_functions, .susi_speed);
